// [logic/wdf_watchdog.v]
// Purpose: Watchdog timer with feed sequence, reached over the SFR port
// Assumes: Watchdog oscillator arrives as a raw level; peripheral clock
//          is core clock divided by two
// Notes:   Peripheral clock ticks stop while the device is powered down
`timescale 1ns/1ps
`include "wdf_map.vh"

module wdf_watchdog (
    input  wire       i_core_clk,
    input  wire       i_reset,
    input  wire       i_clk_en,
    input  wire       i_wdosc_clk,
    input  wire [7:0] i_sfr_addr,
    input  wire       i_sfr_wr,
    input  wire       i_sfr_rd,
    input  wire [7:0] i_sfr_wdata,
    output reg  [7:0] o_sfr_rdata,
    input  wire [7:0] i_user_config,
    input  wire       i_int_en_wdt,
    input  wire       i_power_down,
    input  wire       i_osc_stable,
    output reg        o_wdt_reset,
    output reg        o_osc_restart,
    output reg        o_irq
);
    localparam SW_IDLE = 2'b00;
    localparam SW_OLD  = 2'b01;
    localparam SW_NEW  = 2'b10;

    reg  [7:0] cfg_q;
    reg  [7:0] hold_ctrl_q;
    reg  [7:0] hold_rel_q;
    reg  [2:0] act_pre_q;
    reg        act_run_q;
    reg        act_sel_q;
    reg        eff_sel_q;
    reg        tof_q;
    reg        once_ctrl_q;
    reg        once_rel_q;
    reg        need_feed_q;
    reg  [1:0] sw_state_q;
    reg  [1:0] sw_cnt_q;
    reg        osc_s1_q;
    reg        osc_s2_q;
    reg        osc_s3_q;
    reg        pclk_q;
    reg        rst_seen_q;
    reg        ld_q;

    // Mode decode and register strobes
    wire       rsten    = cfg_q[`WDF_CFG_RSTEN];
    wire       safe     = rsten & cfg_q[`WDF_CFG_SAFE];
    wire       wr_ctrl  = i_sfr_wr && (i_sfr_addr == `WDF_ADDR_CTRL);
    wire       wr_rel   = i_sfr_wr && (i_sfr_addr == `WDF_ADDR_RELOAD);
    wire       wr_feed1 = i_sfr_wr && (i_sfr_addr == `WDF_ADDR_FEED1);
    wire       ctrl_ok  = wr_ctrl & ~(safe & once_ctrl_q);
    wire       rel_ok   = wr_rel & ~(safe & once_rel_q);
    wire       feed;
    wire       bad_feed;
    wire       uf;
    wire       osc_tick  = osc_s2_q & ~osc_s3_q;
    wire       pclk_tick = pclk_q & ~i_power_down;
    wire       old_tick  = eff_sel_q ? osc_tick : pclk_tick;
    wire       new_tick  = act_sel_q ? osc_tick : pclk_tick;
    // Counting pauses while a clock switch is in flight
    wire       wd_tick   = (sw_state_q == SW_IDLE) ? old_tick : 1'b0;
    wire       viol      = need_feed_q & i_sfr_wr & ~wr_feed1;
    // Timer mode never resets, so bad feeds are dropped there
    wire       trig      = rsten & (uf | bad_feed | viol);
    wire       rst_done  = o_wdt_reset & rst_seen_q & i_osc_stable;
    wire       run_eff   = (act_run_q | safe) & ~o_wdt_reset;
    wire       load      = (feed | ld_q) & ~o_wdt_reset;
    wire [7:0] ctrl_wval;
    wire [7:0] ctrl_rd;

    // Safety mode pins select and run high in the holding copy
    assign ctrl_wval = {i_sfr_wdata[7:3],
                        i_sfr_wdata[`WDF_BIT_RUN] | safe,
                        1'b0,
                        i_sfr_wdata[`WDF_BIT_CLKSEL] | safe};

    assign ctrl_rd = {hold_ctrl_q[`WDF_PRE_MSB:`WDF_PRE_LSB],
                      2'b00,
                      hold_ctrl_q[`WDF_BIT_RUN],
                      tof_q,
                      hold_ctrl_q[`WDF_BIT_CLKSEL]};

    wdf_feed_det u_feed (
        .i_core_clk (i_core_clk),
        .i_reset    (i_reset),
        .i_clk_en   (i_clk_en),
        .i_wr       (i_sfr_wr),
        .i_addr     (i_sfr_addr),
        .i_wdata    (i_sfr_wdata),
        .o_feed     (feed),
        .o_bad      (bad_feed)
    );

    wdf_count #(
        .PRE_W (13),
        .CNT_W (8)
    ) u_count (
        .i_core_clk (i_core_clk),
        .i_reset    (i_reset),
        .i_clk_en   (i_clk_en),
        .i_tick     (wd_tick),
        .i_run      (run_eff),
        .i_load     (load),
        .i_reload   (hold_rel_q),
        .i_tap      (act_pre_q),
        .o_uf       (uf)
    );

    // Strap capture and clock sources
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            cfg_q    <= i_user_config;
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
            pclk_q   <= 1'b0;
        end else if (i_clk_en) begin
            osc_s1_q <= i_wdosc_clk;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
            pclk_q   <= ~pclk_q;
        end
    end

    // Holding registers, written by software
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            hold_ctrl_q <= `WDF_CTRL_RST;
            hold_rel_q  <= `WDF_RELOAD_RST;
            once_ctrl_q <= 1'b0;
            once_rel_q  <= 1'b0;
        end else if (i_clk_en) begin
            // A watchdog reset returns both holding registers to defaults
            if (rst_done) begin
                hold_ctrl_q <= `WDF_CTRL_RST;
                hold_rel_q  <= `WDF_RELOAD_RST;
            end else begin
                if (ctrl_ok) begin
                    hold_ctrl_q <= ctrl_wval;
                    once_ctrl_q <= 1'b1;
                end
                if (rel_ok) begin
                    hold_rel_q <= i_sfr_wdata;
                    once_rel_q <= 1'b1;
                end
            end
        end
    end

    // Active control register
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            act_pre_q <= 3'h7;
            act_run_q <= 1'b1;
            act_sel_q <= 1'b1;
        end else if (i_clk_en) begin
            if (rst_done) begin
                act_pre_q <= 3'h7;
                act_run_q <= 1'b1;
                act_sel_q <= 1'b1;
            // Timer mode copies every cycle, watchdog mode only on a feed
            end else if (~rsten | feed) begin
                act_pre_q <= hold_ctrl_q[`WDF_PRE_MSB:`WDF_PRE_LSB];
                act_run_q <= hold_ctrl_q[`WDF_BIT_RUN] | safe;
                act_sel_q <= hold_ctrl_q[`WDF_BIT_CLKSEL] | safe;
            end
        end
    end

    // Pending feed after a control write in watchdog mode
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            need_feed_q <= 1'b0;
        end else if (i_clk_en) begin
            if (rsten & wr_ctrl)
                need_feed_q <= 1'b1;
            else if (wr_feed1 | ~rsten | o_wdt_reset)
                need_feed_q <= 1'b0;
        end
    end

    // Timeout flag: underflow wins over any clear in the same cycle
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            tof_q <= 1'b0;
        end else if (i_clk_en) begin
            if (uf | rst_done)
                tof_q <= 1'b1;
            else if (wr_ctrl & ~i_sfr_wdata[`WDF_BIT_TOF])
                tof_q <= 1'b0;
            else if (rsten & feed)
                tof_q <= 1'b0;
        end
    end

    // Clock source switch: two old ticks, then two new ticks
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            sw_state_q <= SW_IDLE;
            sw_cnt_q   <= 2'h0;
            eff_sel_q  <= 1'b1;
        end else if (i_clk_en) begin
            case (sw_state_q)
                // Only a select that differs from the one in use starts a switch
                SW_IDLE: begin
                    sw_cnt_q <= 2'h0;
                    if (act_sel_q != eff_sel_q)
                        sw_state_q <= SW_OLD;
                end
                SW_OLD: begin
                    if (old_tick) begin
                        if (sw_cnt_q == `WDF_SW_STEPS - 2'h1) begin
                            sw_cnt_q   <= 2'h0;
                            sw_state_q <= SW_NEW;
                        end else begin
                            sw_cnt_q <= sw_cnt_q + 2'h1;
                        end
                    end
                end
                SW_NEW: begin
                    if (new_tick) begin
                        if (sw_cnt_q == `WDF_SW_STEPS - 2'h1) begin
                            sw_cnt_q   <= 2'h0;
                            eff_sel_q  <= act_sel_q;
                            sw_state_q <= SW_IDLE;
                        end else begin
                            sw_cnt_q <= sw_cnt_q + 2'h1;
                        end
                    end
                end
                default: sw_state_q <= SW_IDLE;
            endcase
        end
    end

    // Watchdog reset output and its stretch
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            o_wdt_reset   <= 1'b0;
            rst_seen_q    <= 1'b0;
            o_osc_restart <= 1'b0;
            ld_q          <= 1'b0;
        end else if (i_clk_en) begin
            // Counter reload waits until the reset request has dropped
            ld_q <= rst_done;
            if (o_wdt_reset) begin
                if (old_tick)
                    rst_seen_q <= 1'b1;
                if (rst_done) begin
                    o_wdt_reset <= 1'b0;
                    rst_seen_q  <= 1'b0;
                end
            end else if (trig) begin
                o_wdt_reset <= 1'b1;
                rst_seen_q  <= 1'b0;
            end
            // Keep the oscillator restart up while held in power-down
            o_osc_restart <= o_wdt_reset & i_power_down & ~rst_done;
        end
    end

    // Interrupt request in timer mode
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            o_irq <= 1'b0;
        end else if (i_clk_en) begin
            o_irq <= tof_q & i_int_en_wdt & ~rsten;
        end
    end

    // Registered read port
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            o_sfr_rdata <= 8'h00;
        end else if (i_clk_en && i_sfr_rd) begin
            // Feed registers and unmapped addresses read as zero
            case (i_sfr_addr)
                `WDF_ADDR_CTRL:   o_sfr_rdata <= ctrl_rd;
                `WDF_ADDR_RELOAD: o_sfr_rdata <= hold_rel_q;
                default:          o_sfr_rdata <= 8'h00;
            endcase
        end
    end

endmodule

// [common/wdf_map.vh]
// Purpose: Register map, field positions and reset values of the watchdog
// Assumes: Special-function-register space with 8-bit addresses and data
// Notes:   Included by all watchdog design files
`ifndef WDF_MAP_VH
`define WDF_MAP_VH

`define WDF_ADDR_CTRL     8'hA7
`define WDF_ADDR_RELOAD   8'hC1
`define WDF_ADDR_FEED1    8'hC2
`define WDF_ADDR_FEED2    8'hC3

`define WDF_FEED1_VAL     8'hA5
`define WDF_FEED2_VAL     8'h5A

`define WDF_BIT_CLKSEL    0
`define WDF_BIT_TOF       1
`define WDF_BIT_RUN       2
`define WDF_PRE_LSB       5
`define WDF_PRE_MSB       7

`define WDF_CFG_RSTEN     7
`define WDF_CFG_SAFE      4

`define WDF_CTRL_RST      8'hE5
`define WDF_RELOAD_RST    8'hFF

`define WDF_PRE_BASE      4'h5
`define WDF_SW_STEPS      2'h2

`endif

// [logic/wdf_feed_det.v]
// Purpose: Detects the two-write feed sequence on the register port
// Assumes: One write strobe per cycle, same clock as the core
// Notes:   Pulses are registered and appear one cycle after the write
`timescale 1ns/1ps
`include "wdf_map.vh"

module wdf_feed_det (
    input  wire       i_core_clk,
    input  wire       i_reset,
    input  wire       i_clk_en,
    input  wire       i_wr,
    input  wire [7:0] i_addr,
    input  wire [7:0] i_wdata,
    output reg        o_feed,
    output reg        o_bad
);
    localparam ST_IDLE  = 1'b0;
    localparam ST_ARMED = 1'b1;

    reg state_q;

    always @(posedge i_core_clk) begin
        if (i_reset) begin
            state_q <= ST_IDLE;
            o_feed  <= 1'b0;
            o_bad   <= 1'b0;
        end else if (i_clk_en) begin
            o_feed <= 1'b0;
            o_bad  <= 1'b0;
            if (i_wr) begin
                case (state_q)
                    ST_IDLE: begin
                        if (i_addr == `WDF_ADDR_FEED1) begin
                            if (i_wdata == `WDF_FEED1_VAL)
                                state_q <= ST_ARMED;
                            else
                                o_bad <= 1'b1;
                        end else if (i_addr == `WDF_ADDR_FEED2) begin
                            o_bad <= 1'b1;
                        end
                    end
                    ST_ARMED: begin
                        state_q <= ST_IDLE;
                        if (i_addr == `WDF_ADDR_FEED2 && i_wdata == `WDF_FEED2_VAL)
                            o_feed <= 1'b1;
                        else
                            o_bad <= 1'b1;
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

// [logic/wdf_count.v]
// Purpose: Prescaler with selectable tap feeding an 8-bit down counter
// Assumes: i_tick is a one-cycle watchdog clock tick
// Notes:   Underflow fires one tick after the counter passes zero
`timescale 1ns/1ps
`include "wdf_map.vh"

module wdf_count #(
    parameter PRE_W = 13,
    parameter CNT_W = 8
) (
    input  wire             i_core_clk,
    input  wire             i_reset,
    input  wire             i_clk_en,
    input  wire             i_tick,
    input  wire             i_run,
    input  wire             i_load,
    input  wire [CNT_W-1:0] i_reload,
    input  wire [2:0]       i_tap,
    output reg              o_uf
);
    reg  [PRE_W-1:0] pre_q;
    reg  [CNT_W-1:0] cnt_q;
    reg              pend_q;
    wire [3:0]       shift = 4'h8 - {1'b0, i_tap};
    wire [PRE_W-1:0] mask  = {PRE_W{1'b1}} >> shift;
    wire             wrap  = (pre_q & mask) == mask;

    always @(posedge i_core_clk) begin
        if (i_reset) begin
            pre_q  <= {PRE_W{1'b0}};
            cnt_q  <= {CNT_W{1'b1}};
            pend_q <= 1'b0;
            o_uf   <= 1'b0;
        end else if (i_clk_en) begin
            o_uf <= 1'b0;
            if (i_load) begin
                pre_q  <= {PRE_W{1'b0}};
                cnt_q  <= i_reload;
                pend_q <= 1'b0;
            end else if (i_run && i_tick) begin
                if (pend_q) begin
                    o_uf   <= 1'b1;
                    pend_q <= 1'b0;
                    cnt_q  <= i_reload;
                    pre_q  <= {PRE_W{1'b0}};
                end else begin
                    pre_q <= pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
                    if (wrap) begin
                        if (cnt_q == {CNT_W{1'b0}})
                            pend_q <= 1'b1;
                        else
                            cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
                    end
                end
            end
        end
    end
endmodule

// [tb/wdf_cpu_model.sv]
// Purpose: Core model that drives the special-function-register port
// Assumes: One access at a time, changed just after rising edges
// Notes:   Write data is inverted once released
`timescale 1ns/1ps
`include "wdf_map.vh"

module wdf_cpu_model (
    input  wire       i_core_clk,
    input  wire [7:0] i_rdata,
    output reg  [7:0] o_addr  = 8'h00,
    output reg        o_wr    = 1'b0,
    output reg        o_rd    = 1'b0,
    output reg  [7:0] o_wdata = 8'h00
);
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge i_core_clk);
            o_addr  <= a;
            o_wdata <= d;
            o_wr    <= 1'b1;
            @(posedge i_core_clk);
            o_wr    <= 1'b0;
            o_wdata <= ~d;
        end
    endtask

    task rd(input [7:0] a, output [7:0] d);
        begin
            @(posedge i_core_clk);
            o_addr <= a;
            o_rd   <= 1'b1;
            @(posedge i_core_clk);
            o_rd   <= 1'b0;
            #1;
            d = i_rdata;
        end
    endtask

    // A read between the halves must not break the sequence
    task feed;
        reg [7:0] t;
        begin
            wr(`WDF_ADDR_FEED1, `WDF_FEED1_VAL);
            rd(`WDF_ADDR_CTRL, t);
            wr(`WDF_ADDR_FEED2, `WDF_FEED2_VAL);
        end
    endtask
endmodule

// [tb/wdf_watchdog_checker.sv]
// Purpose: Port-level assertions for the watchdog
// Assumes: Mode bit is captured while reset is held
// Notes:   Bound to every watchdog instance
`timescale 1ns/1ps
`include "wdf_map.vh"

module wdf_watchdog_checker (
    input wire       i_core_clk,
    input wire       i_reset,
    input wire       i_clk_en,
    input wire       i_sfr_wr,
    input wire       i_sfr_rd,
    input wire [7:0] i_sfr_addr,
    input wire [7:0] i_sfr_wdata,
    input wire [7:0] o_sfr_rdata,
    input wire [7:0] i_user_config,
    input wire       i_int_en_wdt,
    input wire       i_osc_stable,
    input wire       o_wdt_reset,
    input wire       o_osc_restart,
    input wire       o_irq
);
    reg rsten_q = 1'b0;
    always @(posedge i_core_clk) begin
        if (i_reset && i_clk_en) begin
            rsten_q <= i_user_config[`WDF_CFG_RSTEN];
        end
    end

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    a_reset_clears_outs: assert property ($fell(i_reset) |->
        !o_wdt_reset && !o_irq && !o_osc_restart) else $error("outputs set after reset");
    a_irq_timer_only: assert property (o_irq |-> !rsten_q)
        else $error("irq in watchdog mode");
    a_no_reset_timer: assert property (!rsten_q |-> !o_wdt_reset)
        else $error("reset in timer mode");
    a_irq_needs_enable: assert property (o_irq |-> $past(i_int_en_wdt))
        else $error("irq while disabled");
    a_bad_feed_reset: assert property (rsten_q && i_clk_en && i_sfr_wr &&
        i_sfr_addr == `WDF_ADDR_FEED1 && i_sfr_wdata != `WDF_FEED1_VAL |-> ##2 o_wdt_reset)
        else $error("bad feed without reset");
    a_reset_min_hold: assert property ($rose(o_wdt_reset) |=> o_wdt_reset)
        else $error("reset too short");
    a_hold_unstable: assert property (o_wdt_reset && !i_osc_stable |=> o_wdt_reset)
        else $error("reset released before osc stable");
    a_restart_in_reset: assert property (o_osc_restart |-> o_wdt_reset)
        else $error("restart outside reset");
    a_feed_reads_zero: assert property (i_clk_en && i_sfr_rd &&
        i_sfr_addr == `WDF_ADDR_FEED2 |=> o_sfr_rdata == 8'h00)
        else $error("feed register read nonzero");

    c_irq: cover property ($rose(o_irq));
    c_wdt_reset: cover property ($rose(o_wdt_reset));
    c_restart: cover property ($rose(o_osc_restart));
endmodule

bind wdf_watchdog wdf_watchdog_checker u_chk (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_clk_en(i_clk_en),
    .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
    .i_user_config(i_user_config), .i_int_en_wdt(i_int_en_wdt),
    .i_osc_stable(i_osc_stable), .o_wdt_reset(o_wdt_reset),
    .o_osc_restart(o_osc_restart), .o_irq(o_irq)
);

// [tb/wdf_watchdog_tb.sv]
// Purpose: Self-checking bench for the watchdog
// Assumes: Oscillator free running at 25 MHz
// Notes:   Tap 0 and reload 0 keep timeouts short
`timescale 1ns/1ps
`include "wdf_map.vh"

module wdf_watchdog_tb;
    reg        clk    = 1'b0;
    reg        rst    = 1'b1;
    reg  [7:0] cfg    = 8'h00;
    reg        osc    = 1'b0;
    reg        int_en = 1'b0;
    reg        pd     = 1'b0;
    reg        stable = 1'b1;
    wire [7:0] addr, wdata, rdata;
    wire       wr, rd, wdt_rst, osc_rst, irq;
    integer    n_mismatch = 0;
    integer    n_compared = 0;
    reg  [7:0] v;

    always #5 clk = ~clk;
    always #20 osc = ~osc;

    wdf_cpu_model u_cpu (.i_core_clk(clk), .i_rdata(rdata), .o_addr(addr),
        .o_wr(wr), .o_rd(rd), .o_wdata(wdata));

    wdf_watchdog u_dut (.i_core_clk(clk), .i_reset(rst), .i_clk_en(1'b1),
        .i_wdosc_clk(osc), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd),
        .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_user_config(cfg),
        .i_int_en_wdt(int_en), .i_power_down(pd), .i_osc_stable(stable),
        .o_wdt_reset(wdt_rst), .o_osc_restart(osc_rst), .o_irq(irq));

    task summarize;
        begin
            $display("compared %0d mismatched %0d", n_compared, n_mismatch);
            if (n_mismatch == 0 && n_compared > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask

    task chk(input [7:0] got, input [7:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    function logic sig(input integer s);
        sig = (s == 0) ? irq : (s == 1) ? wdt_rst : (s == 2) ? !wdt_rst : !irq;
    endfunction

    // lo equal to hi means the signal must stay low for hi cycles
    task wait_for(input integer s, input integer lo, input integer hi);
        integer n;
        begin
            n = 0;
            while (sig(s) !== 1'b1 && n < hi) begin
                @(posedge clk);
                #1;
                n = n + 1;
            end
            n_compared = n_compared + 1;
            if (lo == hi ? n < hi : (n < lo || n >= hi)) begin
                n_mismatch = n_mismatch + 1;
                $display("CHECK FAILED t=%0t event %0d after %0d", $time, s, n);
                if (lo != hi && n >= hi)
                    summarize;
            end
        end
    endtask

    task do_reset(input [7:0] c);
        begin
            @(posedge clk);
            cfg <= c;
            rst <= 1'b1;
            repeat (12) @(posedge clk);
            rst <= 1'b0;
        end
    endtask

    task t_reset_values;
        begin
            do_reset(8'h00);
            u_cpu.rd(`WDF_ADDR_CTRL, v);
            chk(v, 8'hE5);
            u_cpu.rd(`WDF_ADDR_FEED2, v);
            chk(v, 8'h00);
            u_cpu.rd(8'h00, v);
            chk(v, 8'h00);
            $display("test reset_values done");
        end
    endtask

    task t_timer;
        begin
            u_cpu.wr(`WDF_ADDR_RELOAD, 8'h00);
            u_cpu.wr(`WDF_ADDR_CTRL, 8'h04);
            u_cpu.feed;
            wait_for(1, 300, 300);
            u_cpu.rd(`WDF_ADDR_CTRL, v);
            chk(v, 8'h06);
            @(posedge clk);
            int_en <= 1'b1;
            wait_for(0, 0, 4);
            u_cpu.wr(`WDF_ADDR_CTRL, 8'h04);
            wait_for(3, 0, 4);
            wait_for(0, 1, 80);
            u_cpu.wr(`WDF_ADDR_FEED1, 8'h11);
            wait_for(1, 20, 20);
            u_cpu.wr(`WDF_ADDR_CTRL, 8'h00);
            wait_for(3, 0, 4);
            wait_for(0, 200, 200);
            $display("test timer done");
        end
    endtask

    task t_wd_underflow;
        begin
            do_reset(8'h80);
            u_cpu.wr(`WDF_ADDR_RELOAD, 8'h00);
            u_cpu.wr(`WDF_ADDR_CTRL, 8'h04);
            u_cpu.feed;
            wait_for(1, 64, 160);
            wait_for(2, 1, 40);
            u_cpu.rd(`WDF_ADDR_CTRL, v);
            chk(v, 8'hE7);
            $display("test wd_underflow done");
        end
    endtask

    task t_bad_feed;
        begin
            // Let the switch back to the oscillator finish before power-down
            repeat (20) @(posedge clk);
            pd     <= 1'b1;
            stable <= 1'b0;
            u_cpu.wr(`WDF_ADDR_FEED1, 8'h11);
            wait_for(1, 0, 4);
            wait_for(2, 40, 40);
            chk({7'h00, osc_rst}, 8'h01);
            @(posedge clk);
            stable <= 1'b1;
            wait_for(2, 0, 30);
            @(posedge clk);
            pd <= 1'b0;
            u_cpu.wr(`WDF_ADDR_CTRL, 8'hE5);
            u_cpu.wr(`WDF_ADDR_RELOAD, 8'hFF);
            wait_for(1, 0, 4);
            wait_for(2, 1, 40);
            $display("test bad_feed done");
        end
    endtask

    task t_safety;
        begin
            do_reset(8'h90);
            u_cpu.wr(`WDF_ADDR_CTRL, 8'h00);
            u_cpu.feed;
            u_cpu.rd(`WDF_ADDR_CTRL, v);
            chk(v, 8'h05);
            u_cpu.wr(`WDF_ADDR_CTRL, 8'hE0);
            u_cpu.feed;
            u_cpu.rd(`WDF_ADDR_CTRL, v);
            chk(v, 8'h05);
            wait_for(1, 100, 100);
            $display("test safety done");
        end
    endtask

    initial begin
        t_reset_values;
        t_timer;
        t_wd_underflow;
        t_bad_feed;
        t_safety;
        summarize;
    end
endmodule
